// [core/sleep_wake_failsafe_ctrl.sv]
// power mode, bus wake, local wake and failsafe control
// Function
// - sleep turns off spi and inhibit output
// - sleep drops configuration; host reprograms
// - only wake, reset or power exits sleep
// - sleep fault flag set on fault entry
// - bus wake moves to standby, interrupts
// - wake pattern dominant, recessive, dominant
// - short bus activity does not reset monitor
// - request mode drives receive low beyond filter
// - short states never count, long always
// - normal mode or undervoltage discards request
// - window timeout returns to waiting recessive
// - falling receive line wakes sleep to standby
// - local wake on either filtered edge
// - local wake only in sleep and standby
// - test mode bit with test select
// - test mode remaps general pins and interrupt
// - sleep error timer enabled unless disabled while failsafe is off
// - failsafe off until enabled
// - power-up inactivity timer forces sleep
// - wake into standby restarts inactivity timer
// - failsafe wake needs flags cleared, normal
// - persistent silence for inactivity time sleeps
// - one wake interrupt per standby entry
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_failsafe_ctrl
   import swf_pkg::*;
#(
   parameter logic [INACT_W-1:0] INACTIVITY_LIMIT = INACT_W'(INACTIVITY_CYCLES)
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // host mode commands and configuration
   input wire logic go_normal_i,
   input wire logic go_standby_i,
   input wire logic go_sleep_i,
   input wire logic sleep_error_timer_disable_i,
   input wire logic failsafe_enable_i,
   input wire logic test_mode_i,
   input wire logic test_core_sel_i,
   input wire logic power_up_flag_clear_i,
   input wire logic wake_flags_clear_i,
   // status from the rest of the device
   input wire logic bus_silence_flag_i,
   input wire logic regulator_undervoltage_i,
   input wire logic fault_sleep_i,
   // pins and internal lines
   input wire logic bus_dominant_i,
   input wire logic wake_pin_i,
   input wire logic interrupt_pin_i,
   input wire logic general_pin_one_i,
   input wire logic phy_receive_output_i,
   input wire logic core_transmit_i,
   // mode and status outputs
   output logic [1:0] mode_o,
   output logic spi_enable_o,
   output logic inhibit_output_o,
   output logic config_keep_o,
   output logic power_up_flag_o,
   output logic bus_wake_flag_o,
   output logic local_wake_event_o,
   output logic sleep_fault_flag_o,
   // pins
   output logic wake_request_pin_n_o,
   output logic interrupt_pin_n_o,
   output logic interrupt_pin_oe_o,
   output logic general_output_two_o,
   // internal lines and test routing
   output logic bus_wake_request_o,
   output logic internal_receive_o,
   output logic phy_transmit_input_o,
   output logic core_receive_input_o,
   output logic phy_enable_o
);

   // ----------------------------------------
   // pin filters
   // ----------------------------------------
   logic bus_lvl;
   logic bus_edge;
   logic wake_lvl;
   logic wake_edge;

   // short bus states never reach the monitor
   pin_filter #(
      .FILTER_CYCLES(FILT_W'(WAKE_FILTER_CYCLES))
   ) u_bus_filter (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .pin_i(bus_dominant_i),
      .level_o(bus_lvl),
      .edge_o(bus_edge)
   );

   // wake input glitch filter
   pin_filter #(
      .FILTER_CYCLES(FILT_W'(LOCAL_WAKE_FILTER_CYCLES))
   ) u_wake_filter (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .pin_i(wake_pin_i),
      .level_o(wake_lvl),
      .edge_o(wake_edge)
   );

   // ----------------------------------------
   // state
   // ----------------------------------------
   power_mode_t mode_q, mode_d;
   wake_mon_t mon_q, mon_d;
   logic [WIN_W-1:0] win_q, win_d;
   logic req_q, req_d;
   logic rx_q, rx_d;
   logic rx_prev_q, rx_prev_d;
   logic pwr_q, pwr_d;
   logic bwake_q, bwake_d;
   logic lwake_q, lwake_d;
   logic fault_q, fault_d;
   logic irq_given_q, irq_given_d;
   logic after_wake_q, after_wake_d;
   logic bus_wake_ev;
   logic local_ev;
   logic inact_exp;
   logic silence_exp;
   logic inact_run;
   logic inact_clr;

   // ----------------------------------------
   // timers
   // ----------------------------------------
   // power-up timer cannot be disabled; wake timer obeys the disable bit only while failsafe is off
   assign inact_run = (mode_q == MODE_STANDBY) &&
      (pwr_q || (after_wake_q && (!sleep_error_timer_disable_i || failsafe_enable_i)));
   assign inact_clr = power_up_flag_clear_i || wake_flags_clear_i || go_normal_i;

   inactivity_timer u_inact (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .run_i(inact_run),
      .clear_i(inact_clr),
      .limit_i(INACTIVITY_LIMIT),
      .expired_o(inact_exp)
   );

   // silence persisting for the inactivity time
   inactivity_timer u_silence (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .run_i(bus_silence_flag_i && (mode_q != MODE_SLEEP)),
      .clear_i(1'b0),
      .limit_i(INACTIVITY_LIMIT),
      .expired_o(silence_exp)
   );

   // ----------------------------------------
   // wake pattern monitor
   // ----------------------------------------
   // filtered edges advance it; the first step needs only a filtered recessive level
   always_comb begin
      mon_d = mon_q;
      win_d = win_q;
      req_d = req_q;
      rx_d = 1'b1;
      if (mode_q == MODE_NORMAL || regulator_undervoltage_i) begin
         mon_d = MON_WAIT_REC;
         win_d = '0;
         req_d = 1'b0;
      end else begin
         if (mon_q == MON_WAIT_REC2 || mon_q == MON_WAIT_DOM2) begin
            win_d = win_q + 16'h0001;
         end
         case (mon_q)
            MON_WAIT_REC: begin
               if (!bus_lvl) begin
                  mon_d = MON_WAIT_DOM1;
               end
            end
            MON_WAIT_DOM1: begin
               if (bus_edge && bus_lvl) begin
                  mon_d = MON_WAIT_REC2;
                  win_d = '0;
               end
            end
            MON_WAIT_REC2: begin
               if (bus_edge && !bus_lvl) begin
                  mon_d = MON_WAIT_DOM2;
               end
            end
            MON_WAIT_DOM2: begin
               if (bus_edge && bus_lvl) begin
                  mon_d = MON_REQUEST;
                  req_d = 1'b1;
               end
            end
            MON_REQUEST: begin
               rx_d = !bus_lvl;
            end
            default: begin
               mon_d = MON_WAIT_REC;
            end
         endcase
         if ((mon_q == MON_WAIT_REC2 || mon_q == MON_WAIT_DOM2) &&
             win_q >= WIN_W'(WAKE_PATTERN_WINDOW_CYCLES) - 16'h0001) begin
            mon_d = MON_WAIT_REC;
            win_d = '0;
         end
      end
      rx_prev_d = rx_q;
   end

   // falling receive line is the bus wake request
   assign bus_wake_ev = rx_prev_q && !rx_q;
   assign local_ev = wake_edge && (mode_q != MODE_NORMAL);

   // ----------------------------------------
   // mode and flags
   // ----------------------------------------
   always_comb begin
      mode_d = mode_q;
      pwr_d = pwr_q && !power_up_flag_clear_i;
      bwake_d = bwake_q && !wake_flags_clear_i;
      lwake_d = lwake_q && !wake_flags_clear_i;
      fault_d = fault_q;
      irq_given_d = irq_given_q;
      after_wake_d = after_wake_q && !wake_flags_clear_i;
      case (mode_q)
         MODE_SLEEP: begin
            // spi commands have no effect here
            if (bus_wake_ev || local_ev) begin
               mode_d = MODE_STANDBY;
               irq_given_d = 1'b0;
               after_wake_d = 1'b1;
            end
         end
         MODE_STANDBY: begin
            if (go_normal_i) begin
               mode_d = MODE_NORMAL;
            end else if (go_sleep_i) begin
               mode_d = MODE_SLEEP;
               fault_d = 1'b0;
            end else if (inact_exp || silence_exp || fault_sleep_i) begin
               mode_d = MODE_SLEEP;
               fault_d = 1'b1;
            end
         end
         MODE_NORMAL: begin
            if (go_standby_i) begin
               mode_d = MODE_STANDBY;
               irq_given_d = 1'b0;
            end else if (go_sleep_i) begin
               mode_d = MODE_SLEEP;
               fault_d = 1'b0;
            end else if (silence_exp || fault_sleep_i) begin
               mode_d = MODE_SLEEP;
               fault_d = 1'b1;
            end
            after_wake_d = 1'b0;
         end
         default: begin
            mode_d = MODE_STANDBY;
         end
      endcase
      // one wake interrupt per standby entry; set beats clear
      if (!irq_given_q && mode_q != MODE_NORMAL) begin
         if (bus_wake_ev) begin
            bwake_d = 1'b1;
            irq_given_d = 1'b1;
         end else if (local_ev) begin
            lwake_d = 1'b1;
            irq_given_d = 1'b1;
         end
      end
      if (mode_d == MODE_SLEEP && mode_q != MODE_SLEEP) begin
         irq_given_d = 1'b0;
      end
   end

   // registers
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_q <= MODE_STANDBY;
         mon_q <= MON_WAIT_REC;
         win_q <= '0;
         req_q <= 1'b0;
         rx_q <= 1'b1;
         rx_prev_q <= 1'b1;
         pwr_q <= 1'b1;
         bwake_q <= 1'b0;
         lwake_q <= 1'b0;
         fault_q <= 1'b0;
         irq_given_q <= 1'b0;
         after_wake_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         mon_q <= mon_d;
         win_q <= win_d;
         req_q <= req_d;
         rx_q <= rx_d;
         rx_prev_q <= rx_prev_d;
         pwr_q <= pwr_d;
         bwake_q <= bwake_d;
         lwake_q <= lwake_d;
         fault_q <= fault_d;
         irq_given_q <= irq_given_d;
         after_wake_q <= after_wake_d;
      end
   end

   // ----------------------------------------
   // outputs, all registered
   // ----------------------------------------
   logic spi_q, inh_q, keep_q, wkrq_n_q, int_n_q, int_oe_q, general_output_two_q;
   logic phy_tx_q, core_rx_q, phy_en_q;
   logic test_act;

   assign test_act = test_mode_i && (mode_q != MODE_SLEEP);

   // pin drive and test remapping
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         spi_q <= 1'b1;
         inh_q <= 1'b1;
         keep_q <= 1'b1;
         wkrq_n_q <= 1'b1;
         int_n_q <= 1'b1;
         int_oe_q <= 1'b0;
         general_output_two_q <= 1'b1;
         phy_tx_q <= 1'b1;
         core_rx_q <= 1'b1;
         phy_en_q <= 1'b0;
      end else begin
         spi_q <= (mode_d != MODE_SLEEP);
         inh_q <= (mode_d != MODE_SLEEP);
         keep_q <= (mode_d != MODE_SLEEP);
         wkrq_n_q <= !(bwake_d || lwake_d);
         int_n_q <= !(bwake_d || lwake_d || pwr_d || fault_d);
         int_oe_q <= !test_act && (bwake_d || lwake_d || pwr_d || fault_d) &&
            (mode_d != MODE_SLEEP);
         general_output_two_q <= test_act ? (test_core_sel_i ? core_transmit_i : phy_receive_output_i)
            : 1'b1;
         phy_tx_q <= (test_act && !test_core_sel_i) ? general_pin_one_i : 1'b1;
         core_rx_q <= (test_act && test_core_sel_i) ? general_pin_one_i : rx_q;
         phy_en_q <= test_act && !test_core_sel_i && interrupt_pin_i;
      end
   end

   assign mode_o = mode_q;
   assign spi_enable_o = spi_q;
   assign inhibit_output_o = inh_q;
   assign config_keep_o = keep_q;
   assign power_up_flag_o = pwr_q;
   assign bus_wake_flag_o = bwake_q;
   assign local_wake_event_o = lwake_q;
   assign sleep_fault_flag_o = fault_q;
   assign wake_request_pin_n_o = wkrq_n_q;
   assign interrupt_pin_n_o = int_n_q;
   assign interrupt_pin_oe_o = int_oe_q;
   assign general_output_two_o = general_output_two_q;
   assign bus_wake_request_o = req_q;
   assign internal_receive_o = rx_q;
   assign phy_transmit_input_o = phy_tx_q;
   assign core_receive_input_o = core_rx_q;
   assign phy_enable_o = phy_en_q;

endmodule
`default_nettype wire

// [core/swf_pkg.sv]
// package of constants for the sleep, wake and failsafe controller
package swf_pkg;

   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_FREQ_HZ = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS = 100;
   // inactivity timeout of about four minutes, in seconds
   localparam int unsigned INACTIVITY_TIMEOUT_S = 240;
   localparam longint unsigned INACTIVITY_CYCLES = 64'(INACTIVITY_TIMEOUT_S) * 64'(CLK_FREQ_HZ);
   // bus wake filter time
   localparam int unsigned WAKE_FILTER_TIME_NS = 1000;
   localparam int unsigned WAKE_FILTER_CYCLES =
      (WAKE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // wake pattern window
   localparam int unsigned WAKE_PATTERN_WINDOW_US = 1000;
   localparam int unsigned WAKE_PATTERN_WINDOW_CYCLES =
      (WAKE_PATTERN_WINDOW_US * 1000) / CLK_PERIOD_NS;
   // local wake glitch filter
   localparam int unsigned LOCAL_WAKE_FILTER_NS = 1000;
   localparam int unsigned LOCAL_WAKE_FILTER_CYCLES =
      (LOCAL_WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------
   // counter widths
   // ----------------------------------------
   localparam int unsigned INACT_W = 32;
   localparam int unsigned FILT_W = 8;
   localparam int unsigned WIN_W = 16;

   // ----------------------------------------
   // configuration and status bit positions
   // ----------------------------------------
   localparam logic [15:0] CONFIG_REG_ADDR = 16'h0800;
   localparam logic [15:0] IRQ_REG_ADDR = 16'h0820;
   localparam int unsigned TEST_SEL_BIT = 0;
   localparam int unsigned SLEEP_ERR_DIS_BIT = 1;
   localparam int unsigned FAILSAFE_EN_BIT = 13;
   localparam int unsigned TEST_MODE_BIT = 21;
   localparam int unsigned SLEEP_FAULT_BIT = 23;
   localparam logic SLEEP_ERR_DIS_RESET = 1'b0;
   localparam logic FAILSAFE_EN_RESET = 1'b0;

   // ----------------------------------------
   // modes and monitor states
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_SLEEP,
      MODE_STANDBY,
      MODE_NORMAL
   } power_mode_t;

   typedef enum logic [2:0] {
      MON_WAIT_REC,
      MON_WAIT_DOM1,
      MON_WAIT_REC2,
      MON_WAIT_DOM2,
      MON_REQUEST
   } wake_mon_t;

endpackage

// [core/pin_filter.sv]
// input synchroniser and minimum-duration filter for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_filter
   import swf_pkg::*;
#(
   parameter logic [FILT_W-1:0] FILTER_CYCLES = 8'h01
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // raw pin and filtered level
   input wire logic pin_i,
   output logic level_o,
   output logic edge_o
);

   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic stable_q;
   logic stable_d;
   logic level_q;
   logic level_d;
   logic edge_q;
   logic edge_d;
   logic [FILT_W-1:0] cnt_q;
   logic [FILT_W-1:0] cnt_d;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // a change counts once the second and third stage agree
   always_comb begin
      sync_d = {sync_q[1:0], pin_i};
      stable_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : stable_q;
      level_d = level_q;
      edge_d = 1'b0;
      cnt_d = cnt_q;
      if (stable_q == level_q) begin
         cnt_d = '0;
      end else if (cnt_q >= FILTER_CYCLES - 8'h01) begin
         level_d = stable_q;
         edge_d = 1'b1;
         cnt_d = '0;
      end else begin
         cnt_d = cnt_q + 8'h01;
      end
   end

   // registers
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync_q <= '0;
         stable_q <= 1'b0;
         level_q <= 1'b0;
         edge_q <= 1'b0;
         cnt_q <= '0;
      end else begin
         sync_q <= sync_d;
         stable_q <= stable_d;
         level_q <= level_d;
         edge_q <= edge_d;
         cnt_q <= cnt_d;
      end
   end

   assign level_o = level_q;
   assign edge_o = edge_q;

endmodule
`default_nettype wire

// [core/inactivity_timer.sv]
// inactivity counter that raises a one-cycle expiry
`timescale 1ns/1ps
`default_nettype none
module inactivity_timer
   import swf_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // control
   input wire logic run_i,
   input wire logic clear_i,
   input wire logic [INACT_W-1:0] limit_i,
   output logic expired_o
);

   logic [INACT_W-1:0] cnt_q;
   logic [INACT_W-1:0] cnt_d;
   logic exp_q;
   logic exp_d;

   // count while running, clear wins
   always_comb begin
      cnt_d = cnt_q;
      exp_d = 1'b0;
      if (clear_i || !run_i) begin
         cnt_d = '0;
      end else if (cnt_q >= limit_i - 32'h0000_0001) begin
         cnt_d = '0;
         exp_d = 1'b1;
      end else begin
         cnt_d = cnt_q + 32'h0000_0001;
      end
   end

   // registers
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_q <= '0;
         exp_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         exp_q <= exp_d;
      end
   end

   assign expired_o = exp_q;

endmodule
`default_nettype wire

// [tb/swf_assertions.sv]
// checker of the controller ports
`timescale 1ns/1ps
`default_nettype none
module swf_assertions
   import swf_pkg::*;
(
   // clock, reset and inputs
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic go_normal_i,
   input wire logic fault_sleep_i,
   input wire logic test_mode_i,
   input wire logic test_core_sel_i,
   input wire logic general_pin_one_i,
   input wire logic core_transmit_i,
   input wire logic interrupt_pin_i,
   // outputs watched
   input wire logic [1:0] mode_o,
   input wire logic spi_enable_o,
   input wire logic inhibit_output_o,
   input wire logic config_keep_o,
   input wire logic bus_wake_flag_o,
   input wire logic local_wake_event_o,
   input wire logic sleep_fault_flag_o,
   input wire logic bus_wake_request_o,
   input wire logic internal_receive_o,
   input wire logic phy_transmit_input_o,
   input wire logic core_receive_input_o,
   input wire logic general_output_two_o,
   input wire logic phy_enable_o
);
   // ----------------------------------------
   // sequences and properties
   // ----------------------------------------
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   sequence s_asleep;
      mode_o == MODE_SLEEP;
   endsequence
   sequence s_phy_test;
      test_mode_i && !test_core_sel_i;
   endsequence
   property p_sleep_off;
      s_asleep |-> !spi_enable_o && !inhibit_output_o && !config_keep_o;
   endproperty
   a_sleep_off: assert property (p_sleep_off)
      else $error("spi, inhibit or config kept in sleep");
   property p_no_exit;
      s_asleep ##0 go_normal_i |=> mode_o != MODE_NORMAL;
   endproperty
   a_no_exit: assert property (p_no_exit)
      else $error("command left sleep");
   property p_fault;
      fault_sleep_i |-> ##[1:3] (mode_o == MODE_SLEEP && sleep_fault_flag_o);
   endproperty
   a_fault: assert property (p_fault)
      else $error("fault did not reach sleep with flag");
   property p_wake_up;
      $rose(bus_wake_flag_o) |-> mode_o == MODE_STANDBY;
   endproperty
   a_wake_up: assert property (p_wake_up)
      else $error("bus wake flag outside standby");
   property p_rx_low;
      !internal_receive_o |-> bus_wake_request_o;
   endproperty
   a_rx_low: assert property (p_rx_low)
      else $error("receive line low outside request mode");
   property p_normal_drop;
      (mode_o == MODE_NORMAL) [*2] |-> !bus_wake_request_o;
   endproperty
   a_normal_drop: assert property (p_normal_drop)
      else $error("wake request kept in normal");
   property p_local;
      $rose(local_wake_event_o) |-> mode_o != MODE_NORMAL;
   endproperty
   a_local: assert property (p_local)
      else $error("local wake in normal");
   property p_phy_route;
      s_phy_test |=> phy_transmit_input_o == $past(general_pin_one_i)
         && phy_enable_o == $past(interrupt_pin_i);
   endproperty
   a_phy_route: assert property (p_phy_route)
      else $error("transceiver test routing wrong");
   property p_core_route;
      test_mode_i && test_core_sel_i |=> core_receive_input_o == $past(general_pin_one_i)
         && general_output_two_o == $past(core_transmit_i);
   endproperty
   a_core_route: assert property (p_core_route)
      else $error("core test routing wrong");
endmodule
bind sleep_wake_failsafe_ctrl swf_assertions u_chk (.*);
`default_nettype wire

// [tb/host_model.sv]
// host model issuing mode commands and flag clears
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock and interrupt wire
   input wire logic clock_i,
   input wire logic int_n_i,
   // commands to the controller
   output logic go_normal_o,
   output logic go_standby_o,
   output logic go_sleep_o,
   output logic power_up_flag_clear_o,
   output logic wake_flags_clear_o
);
   logic [4:0] cmd_q = 5'h00;
   // command bits in one vector
   assign {go_normal_o, go_standby_o, go_sleep_o} = cmd_q[4:2];
   assign {power_up_flag_clear_o, wake_flags_clear_o} = cmd_q[1:0];
   // one-cycle pulse after an edge
   task automatic pulse(input logic [4:0] sel);
      @(posedge clock_i);
      #1 cmd_q = sel;
      @(posedge clock_i);
      #1 cmd_q = 5'h00;
   endtask
   // await interrupt, clear flags, go normal
   task automatic service();
      for (int i = 0; i < 8 && int_n_i !== 1'b0; i++) @(posedge clock_i);
      pulse(5'h03);
      pulse(5'h10);
   endtask
endmodule
`default_nettype wire

// [tb/sleep_wake_failsafe_ctrl_test.sv]
// self-checking bench of the controller
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_failsafe_ctrl_test
   import swf_pkg::*;
;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   localparam logic [31:0] LIM = 32'h0000_0100;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic err_dis = 1'b0, test_mode = 1'b0, test_sel = 1'b0, silence = 1'b0;
   logic fault = 1'b0, bus = 1'b0, wake_pin = 1'b0, int_drv = 1'b1;
   logic gp1 = 1'b0, phy_rx = 1'b0, core_tx = 1'b0, fs_en = 1'b0, uv = 1'b0;
   wire logic go_n, go_s, go_z, pu_clr, wk_clr, int_n, int_oe, int_wire;
   wire logic [1:0] mode_o;
   wire logic spi, inhibit_output, keep, pu_flag, bw_flag, lw_event, sf_flag, wrq_n;
   wire logic general_output_two, bw_req, rx_int, phy_tx, core_rx, phy_en;
   int bad_count = 0;
   int n_checks = 0;
   // open-drain interrupt wire with pull-up
   assign int_wire = ~int_oe & int_drv;
   sleep_wake_failsafe_ctrl #(.INACTIVITY_LIMIT(LIM)) DUT (
      .clock_i(clock_i), .rstn_i(rstn_i), .go_normal_i(go_n), .go_standby_i(go_s),
      .go_sleep_i(go_z), .sleep_error_timer_disable_i(err_dis), .failsafe_enable_i(fs_en),
      .test_mode_i(test_mode), .test_core_sel_i(test_sel), .power_up_flag_clear_i(pu_clr),
      .wake_flags_clear_i(wk_clr), .bus_silence_flag_i(silence),
      .regulator_undervoltage_i(uv), .fault_sleep_i(fault), .bus_dominant_i(bus),
      .wake_pin_i(wake_pin), .interrupt_pin_i(int_wire), .general_pin_one_i(gp1),
      .phy_receive_output_i(phy_rx), .core_transmit_i(core_tx), .mode_o(mode_o),
      .spi_enable_o(spi), .inhibit_output_o(inhibit_output), .config_keep_o(keep),
      .power_up_flag_o(pu_flag), .bus_wake_flag_o(bw_flag), .local_wake_event_o(lw_event),
      .sleep_fault_flag_o(sf_flag), .wake_request_pin_n_o(wrq_n),
      .interrupt_pin_n_o(int_n), .interrupt_pin_oe_o(int_oe),
      .general_output_two_o(general_output_two), .bus_wake_request_o(bw_req),
      .internal_receive_o(rx_int), .phy_transmit_input_o(phy_tx),
      .core_receive_input_o(core_rx), .phy_enable_o(phy_en)
   );
   host_model host (
      .clock_i(clock_i), .int_n_i(int_wire), .go_normal_o(go_n), .go_standby_o(go_s),
      .go_sleep_o(go_z), .power_up_flag_clear_o(pu_clr), .wake_flags_clear_o(wk_clr)
   );
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   // whole cycles, just past the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %0d seen %0d", nm, exp, got);
      end
   endtask
   // bounded wait for a mode
   task automatic wait_mode(input logic [1:0] exp, input int max);
      for (int i = 0; i < max && mode_o !== exp; i++) cyc(1);
      chk("mode", exp, mode_o);
   endtask
   task automatic drive_bus(input logic lvl, input int n);
      bus = lvl;
      cyc(n);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_power_up();
      chk("power_up_flag", 1'b1, pu_flag);
      cyc(150);
      chk("mode", MODE_STANDBY, mode_o);
      wait_mode(MODE_SLEEP, 200);
      chk("spi", 1'b0, spi);
      chk("inhibit", 1'b0, inhibit_output);
      chk("config_keep", 1'b0, keep);
      host.pulse(5'h10);
      host.pulse(5'h08);
      cyc(3);
      chk("mode", MODE_SLEEP, mode_o);
      $display("test power_up done");
   endtask
   task automatic t_bus_wake();
      repeat (6) begin
         drive_bus(1'b1, 5);
         drive_bus(1'b0, 5);
      end
      cyc(30);
      chk("mode", MODE_SLEEP, mode_o);
      drive_bus(1'b1, 20);
      drive_bus(1'b0, 3);
      drive_bus(1'b1, 5);
      drive_bus(1'b0, 15);
      drive_bus(1'b1, 3);
      drive_bus(1'b0, 15);
      drive_bus(1'b1, 30);
      chk("bus_wake_request", 1'b1, bw_req);
      chk("internal_receive", 1'b0, rx_int);
      wait_mode(MODE_STANDBY, 20);
      chk("bus_wake_flag", 1'b1, bw_flag);
      chk("wake_request_pin_n", 1'b0, wrq_n);
      chk("interrupt_pin_n", 1'b0, int_n);
      drive_bus(1'b0, 20);
      chk("internal_receive", 1'b1, rx_int);
      uv = 1'b1;
      cyc(2);
      uv = 1'b0;
      chk("bus_wake_request", 1'b0, bw_req);
      host.pulse(5'h02);
      cyc(2);
      chk("power_up_flag", 1'b0, pu_flag);
      wait_mode(MODE_SLEEP, 400);
      $display("test bus_wake done");
   endtask
   task automatic t_local_wake();
      err_dis = 1'b1;
      wake_pin = 1'b1;
      cyc(3);
      wake_pin = 1'b0;
      cyc(30);
      chk("mode", MODE_SLEEP, mode_o);
      wake_pin = 1'b1;
      wait_mode(MODE_STANDBY, 40);
      chk("local_wake_event", 1'b1, lw_event);
      cyc(400);
      chk("mode", MODE_STANDBY, mode_o);
      fs_en = 1'b1;
      wait_mode(MODE_SLEEP, 300);
      wake_pin = 1'b0;
      wait_mode(MODE_STANDBY, 40);
      host.service();
      cyc(3);
      chk("mode", MODE_NORMAL, mode_o);
      chk("bus_wake_request", 1'b0, bw_req);
      chk("local_wake_event", 1'b0, lw_event);
      wake_pin = 1'b1;
      cyc(40);
      chk("mode", MODE_NORMAL, mode_o);
      chk("local_wake_event", 1'b0, lw_event);
      $display("test local_wake done");
   endtask
   task automatic silence_timeout();
      silence = 1'b1;
      cyc(150);
      chk("mode", MODE_NORMAL, mode_o);
      wait_mode(MODE_SLEEP, 200);
      silence = 1'b0;
      rstn_i = 1'b0;
      cyc(2);
      rstn_i = 1'b1;
      cyc(1);
      chk("mode", MODE_STANDBY, mode_o);
      $display("test silence done");
   endtask
   task automatic t_test_route();
      test_mode = 1'b1;
      gp1 = 1'b1;
      phy_rx = 1'b1;
      int_drv = 1'b0;
      cyc(2);
      chk("phy_transmit", 1'b1, phy_tx);
      chk("general_output_two", 1'b1, general_output_two);
      chk("phy_enable", 1'b0, phy_en);
      test_sel = 1'b1;
      int_drv = 1'b1;
      core_tx = 1'b1;
      cyc(2);
      chk("core_receive", 1'b1, core_rx);
      chk("general_output_two", 1'b1, general_output_two);
      core_tx = 1'b0;
      gp1 = 1'b0;
      cyc(2);
      chk("core_receive", 1'b0, core_rx);
      chk("general_output_two", 1'b0, general_output_two);
      test_mode = 1'b0;
      fault = 1'b1;
      cyc(1);
      fault = 1'b0;
      wait_mode(MODE_SLEEP, 5);
      chk("sleep_fault_flag", 1'b1, sf_flag);
      $display("test test_route done");
   endtask
   // ----------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      forever #50 clock_i = ~clock_i;
   end
   initial begin
      #1_000_000;
      bad_count++;
      complete_run();
   end
   initial begin
      cyc(5);
      rstn_i = 1'b1;
      cyc(1);
      t_power_up();
      t_bus_wake();
      t_local_wake();
      silence_timeout();
      t_test_route();
      complete_run();
   end
endmodule
`default_nettype wire
